// ===== src/free_process_pid_regs.vh
// Register map, field positions and constants of the process PID controller
`ifndef FREE_PROCESS_PID_REGS_VH
`define FREE_PROCESS_PID_REGS_VH

// Register byte offsets
`define R_UNIT_REF      8'h00
`define R_SAMPLE_SEL    8'h04
`define R_STATUS        8'h08
`define R_SP_SRC        8'h0c
`define R_RISE_TIME     8'h10
`define R_FALL_TIME     8'h14
`define R_RAMP_OUT      8'h18
`define R_DEV_INV       8'h1c
`define R_FB_SRC        8'h20
`define R_FB_SMOOTH     8'h24
`define R_FB_UPPER      8'h28
`define R_FB_LOWER      8'h2c
`define R_FB_INV        8'h30
`define R_FB_OUT        8'h34
`define R_DEV_OUT       8'h38
`define R_DERIV_TIME    8'h3c
`define R_PROP_GAIN     8'h40
`define R_INTEG_TIME    8'h44
`define R_UNIT_SEL      8'h48
`define R_INHIBIT       8'h4c
`define R_CTRL_OUT      8'h50

// Reset values; signals Q16.16 with 1.0 = 100 %, times in ms
`define RST_UNIT_REF    32'h0001_0000
`define RST_SAMPLE_SEL  16'h0001
`define RST_RAMP_TIME   32'h0000_03e8
`define RST_SMOOTH      32'h0000_0000
`define RST_FB_UPPER    32'h0001_0000
`define RST_FB_LOWER    32'hffff_0000
`define RST_DERIV       32'h0000_0000
`define RST_PROP_GAIN   32'h0001_0000
`define RST_INTEG       32'h0000_7530
`define RST_UNIT_SEL    16'h0001
`define UNIT_REF_MIN    32'h0000_028f
`define UNIT_PERCENT    16'h0001

// Sampling period codes
`define SAMPLE_MIN_CODE 16'h0001
`define SAMPLE_MAX_CODE 16'h0004
`define T_BASE_MS       32'h0000_0080
`define CLK_KHZ         32'h0001_e848

// Output limits of the controller
`define OUT_MAX         32'h0001_0000
`define OUT_MIN         32'h0000_0000

// Status word bits
`define ST_DEACT        0
`define ST_LIMITED      1
`define ST_FB_MIN       8
`define ST_FB_MAX       9
`define ST_OUT_MIN      10
`define ST_OUT_MAX      11

`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
`define Q_FRAC          16
`endif

// ===== src/free_process_pid_controller.v
// Process PID controller with setpoint ramp and AXI4-Lite register slave
`timescale 1ns/1ps
`include "free_process_pid_regs.vh"
// Overview of operation
// - Sampling period codes 1..4: 128..1024 ms
// - Status bit0 deactivated, bit1 limited
// - Status bits 8/9: feedback at limit
// - Status bits 10/11: output at limit
// - Setpoint ramps up over rise time
// - Setpoint ramps down over fall time
// - Ramped setpoint is readable
// - Inversion off: deviation used unchanged
// - Inversion on: deviation negated
// - Feedback first-order lag, zero bypasses
// - Feedback clamped to upper limit
// - Feedback clamped to lower limit
// - Optional feedback negation, default off
// - Clamped feedback is readable
// - System deviation is readable
// - Derivative time zero disables D term
// - Proportional gain zero disables P term
// - Integral time zero disables integration
// - Integral term frozen when time zeroed
// - Absolute units scale against reference
// - Setpoint taken from selected source
// - Feedback taken from selected source
// - Enable input switches controller in/out
module free_process_pid_controller #(
   parameter N_SRC       = 4,
   parameter BASE_CYCLES = `T_BASE_MS * `CLK_KHZ
) (
   // Clock and reset
   input  wire                 i_core_clk,
   input  wire                 i_arst_n,
   // Drive signal sources, Q16.16 each
   input  wire [N_SRC*32-1:0]  i_src_bus,
   input  wire                 i_enable,
   // Controller result
   output reg  [31:0]          o_speed_setpoint,
   output reg  [11:0]          o_status,
   output reg                  o_sample_tick,
   // AXI4-Lite write channels
   input  wire                 i_s_axi_awvalid,
   output reg                  o_s_axi_awready,
   input  wire [7:0]           i_s_axi_awaddr,
   input  wire                 i_s_axi_wvalid,
   output reg                  o_s_axi_wready,
   input  wire [31:0]          i_s_axi_wdata,
   input  wire [3:0]           i_s_axi_wstrb,
   output reg                  o_s_axi_bvalid,
   input  wire                 i_s_axi_bready,
   output reg  [1:0]           o_s_axi_bresp,
   // AXI4-Lite read channels
   input  wire                 i_s_axi_arvalid,
   output reg                  o_s_axi_arready,
   input  wire [7:0]           i_s_axi_araddr,
   output reg                  o_s_axi_rvalid,
   input  wire                 i_s_axi_rready,
   output reg  [31:0]          o_s_axi_rdata,
   output reg  [1:0]           o_s_axi_rresp
);

   // Settings
   reg  [31:0] unit_ref_q;
   reg  [15:0] sample_sel_q;
   reg  [31:0] sp_src_q;
   reg  [31:0] rise_q;
   reg  [31:0] fall_q;
   reg  [15:0] dev_inv_q;
   reg  [31:0] fb_src_q;
   reg  [31:0] smooth_q;
   reg  [31:0] fb_upper_q;
   reg  [31:0] fb_lower_q;
   reg  [15:0] fb_inv_q;
   reg  [31:0] deriv_q;
   reg  [31:0] kp_q;
   reg  [31:0] integ_time_q;
   reg  [15:0] unit_sel_q;
   reg         release_q;
   // Controller state
   reg  [31:0] tick_cnt_q;
   reg  [31:0] ramp_q;
   reg  [31:0] filt_q;
   reg  [31:0] fb_clamp_q;
   reg  [31:0] dev_q;
   reg  [31:0] integ_q;
   // Bus state
   reg  [7:0]  aw_addr_q;
   reg  [31:0] w_data_q;
   reg  [3:0]  w_strb_q;
   reg         aw_got_q;
   reg         w_got_q;

   function [31:0] mulq;
      input [31:0] a;
      input [31:0] b;
      reg signed [63:0] p;
      begin
         p = $signed(a) * $signed(b);
         mulq = p[47:16];
      end
   endfunction

   // Unsigned ratio n/d in Q16.16, saturating
   function [31:0] divq;
      input [31:0] n;
      input [31:0] d;
      reg [47:0] q;
      begin
         q = 48'h0;
         if (d != 32'h0) begin
            q = {n, 16'h0} / {16'h0, d};
         end
         if (d == 32'h0 || q[47:31] != 17'h0) begin
            divq = 32'h7fff_ffff;
         end else begin
            divq = q[31:0];
         end
      end
   endfunction

   // Signed Q16.16 value divided by unsigned Q16.16 value
   function [31:0] divs;
      input [31:0] n;
      input [31:0] d;
      reg signed [63:0] q;
      begin
         q = $signed({{16{n[31]}}, n, 16'h0}) / $signed({32'h0, d});
         divs = q[31:0];
      end
   endfunction

   function [31:0] clamp;
      input [33:0] v;
      input [31:0] lo;
      input [31:0] hi;
      begin
         if ($signed(v) < $signed({{2{lo[31]}}, lo})) begin
            clamp = lo;
         end else if ($signed(v) > $signed({{2{hi[31]}}, hi})) begin
            clamp = hi;
         end else begin
            clamp = v[31:0];
         end
      end
   endfunction

   function [31:0] srcsel;
      input [31:0]          idx;
      input [N_SRC*32-1:0] bus;
      integer k;
      begin
         srcsel = 32'h0;
         for (k = 0; k < N_SRC; k = k + 1) begin
            if (idx == k) begin
               srcsel = bus[k*32 +: 32];
            end
         end
      end
   endfunction

   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0]  strb;
      integer k;
      begin
         merge = old;
         for (k = 0; k < 4; k = k + 1) begin
            if (strb[k]) begin
               merge[k*8 +: 8] = nw[k*8 +: 8];
            end
         end
      end
   endfunction

   function [31:0] to_unit;
      input [31:0] v;
      input        abs_mode;
      input [31:0] ref_q;
      begin
         to_unit = abs_mode ? mulq(v, ref_q) : v;
      end
   endfunction

   // Sampling period
   reg  [31:0] ts_ms;
   reg  [31:0] ts_cycles;
   reg         code_ok;
   reg         active;
   reg         abs_mode;
   reg         tick;
   // Per-sample arithmetic
   reg  [31:0] sp_in;
   reg  [31:0] fb_in;
   reg  [32:0] sp_diff;
   reg  [31:0] step_up;
   reg  [31:0] step_dn;
   reg  [31:0] ramp_d;
   reg  [31:0] alpha;
   reg  [31:0] filt_d;
   reg  [31:0] lim_hi;
   reg  [31:0] lim_lo;
   reg  [31:0] fb_clamp_d;
   reg  [31:0] dev_raw;
   reg  [31:0] dev_d;
   reg  [31:0] p_term;
   reg  [31:0] integ_d;
   reg  [31:0] d_term;
   reg  [33:0] pid_sum;
   reg  [31:0] out_d;

   always @* begin
      code_ok = sample_sel_q >= `SAMPLE_MIN_CODE && sample_sel_q <= `SAMPLE_MAX_CODE;
      ts_ms = code_ok ? (`T_BASE_MS << (sample_sel_q[2:0] - 3'h1)) : `T_BASE_MS;
      ts_cycles = code_ok ? (BASE_CYCLES << (sample_sel_q[2:0] - 3'h1)) : BASE_CYCLES;
      tick = code_ok && (tick_cnt_q >= ts_cycles - 32'h1);
      active = i_enable && release_q && code_ok;
      abs_mode = unit_sel_q != `UNIT_PERCENT;
      sp_in = srcsel(sp_src_q, i_src_bus);
      fb_in = srcsel(fb_src_q, i_src_bus);
      // Setpoint ramp, rates for a full 100 % swing
      step_up = (rise_q == 32'h0) ? 32'h7fff_ffff : divq(ts_ms, rise_q);
      step_dn = (fall_q == 32'h0) ? 32'h7fff_ffff : divq(ts_ms, fall_q);
      sp_diff = {sp_in[31], sp_in} - {ramp_q[31], ramp_q};
      ramp_d = sp_in;
      if ($signed(sp_diff) > $signed({1'b0, step_up})) begin
         ramp_d = ramp_q + step_up;
      end else if ($signed(sp_diff) < -$signed({1'b0, step_dn})) begin
         ramp_d = ramp_q - step_dn;
      end
      // Feedback inversion, smoothing and clamping
      if (fb_inv_q[0]) begin
         fb_in = 32'h0 - fb_in;
      end
      alpha = divq(ts_ms, smooth_q + ts_ms);
      filt_d = (smooth_q == 32'h0) ? fb_in : filt_q + mulq(alpha, fb_in - filt_q);
      lim_hi = abs_mode ? divs(fb_upper_q, unit_ref_q) : fb_upper_q;
      lim_lo = abs_mode ? divs(fb_lower_q, unit_ref_q) : fb_lower_q;
      fb_clamp_d = clamp({{2{filt_d[31]}}, filt_d}, lim_lo, lim_hi);
      dev_raw = ramp_d - fb_clamp_d;
      dev_d = dev_inv_q[0] ? 32'h0 - dev_raw : dev_raw;
      p_term = mulq(kp_q, dev_d);
      integ_d = integ_q;
      if (integ_time_q != 32'h0) begin
         integ_d = integ_q + mulq(kp_q, mulq(divq(ts_ms, integ_time_q), dev_d));
      end
      d_term = 32'h0;
      if (deriv_q != 32'h0) begin
         d_term = mulq(kp_q, mulq(divq(deriv_q, ts_ms), dev_d - dev_q));
      end
      pid_sum = {{2{p_term[31]}}, p_term} + {{2{integ_d[31]}}, integ_d}
              + {{2{d_term[31]}}, d_term};
      out_d = clamp(pid_sum, `OUT_MIN, `OUT_MAX);
   end

   // Sampling and control loop
   always @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         tick_cnt_q       <= 32'h0;
         o_sample_tick    <= 1'b0;
         ramp_q           <= 32'h0;
         filt_q           <= 32'h0;
         fb_clamp_q       <= 32'h0;
         dev_q            <= 32'h0;
         integ_q          <= 32'h0;
         o_speed_setpoint <= 32'h0;
         o_status         <= 12'h1;
      end else begin
         tick_cnt_q    <= (tick || !code_ok) ? 32'h0 : tick_cnt_q + 32'h1;
         o_sample_tick <= tick;
         o_status[`ST_DEACT] <= !active;
         if (tick) begin
            filt_q     <= filt_d;
            fb_clamp_q <= fb_clamp_d;
            o_status[`ST_FB_MIN] <= fb_clamp_d == lim_lo;
            o_status[`ST_FB_MAX] <= fb_clamp_d == lim_hi;
            if (active) begin
               ramp_q  <= ramp_d;
               dev_q   <= dev_d;
               integ_q <= integ_d;
               o_speed_setpoint <= out_d;
               o_status[`ST_OUT_MIN] <= out_d == `OUT_MIN;
               o_status[`ST_OUT_MAX] <= out_d == `OUT_MAX;
               o_status[`ST_LIMITED] <= out_d != pid_sum[31:0] ||
                                        pid_sum[33:31] == 3'h1 || pid_sum[33:31] == 3'h6;
            end else begin
               // Switched out: output idle, ramp tracks input
               ramp_q  <= sp_in;
               dev_q   <= 32'h0;
               integ_q <= 32'h0;
               o_speed_setpoint <= 32'h0;
               o_status[`ST_OUT_MIN] <= 1'b0;
               o_status[`ST_OUT_MAX] <= 1'b0;
               o_status[`ST_LIMITED] <= 1'b0;
            end
         end
      end
   end

   // Register write path
   wire do_write = aw_got_q && w_got_q && !o_s_axi_bvalid;
   reg  [31:0] wr_val;
   reg         wr_hit;

   always @* begin
      wr_hit = 1'b1;
      case (aw_addr_q)
         `R_UNIT_REF:   wr_val = unit_ref_q;
         `R_SAMPLE_SEL: wr_val = {16'h0, sample_sel_q};
         `R_SP_SRC:     wr_val = sp_src_q;
         `R_RISE_TIME:  wr_val = rise_q;
         `R_FALL_TIME:  wr_val = fall_q;
         `R_DEV_INV:    wr_val = {16'h0, dev_inv_q};
         `R_FB_SRC:     wr_val = fb_src_q;
         `R_FB_SMOOTH:  wr_val = smooth_q;
         `R_FB_UPPER:   wr_val = fb_upper_q;
         `R_FB_LOWER:   wr_val = fb_lower_q;
         `R_FB_INV:     wr_val = {16'h0, fb_inv_q};
         `R_DERIV_TIME: wr_val = deriv_q;
         `R_PROP_GAIN:  wr_val = kp_q;
         `R_INTEG_TIME: wr_val = integ_time_q;
         `R_UNIT_SEL:   wr_val = {16'h0, unit_sel_q};
         `R_INHIBIT:    wr_val = {31'h0, release_q};
         default: begin
            wr_val = 32'h0;
            wr_hit = 1'b0;
         end
      endcase
      wr_val = merge(wr_val, w_data_q, w_strb_q);
   end

   always @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_s_axi_awready <= 1'b1;
         o_s_axi_wready  <= 1'b1;
         o_s_axi_bvalid  <= 1'b0;
         o_s_axi_bresp   <= `RESP_OKAY;
         aw_got_q        <= 1'b0;
         w_got_q         <= 1'b0;
         aw_addr_q       <= 8'h0;
         w_data_q        <= 32'h0;
         w_strb_q        <= 4'h0;
         unit_ref_q      <= `RST_UNIT_REF;
         sample_sel_q    <= `RST_SAMPLE_SEL;
         sp_src_q        <= 32'h0;
         rise_q          <= `RST_RAMP_TIME;
         fall_q          <= `RST_RAMP_TIME;
         dev_inv_q       <= 16'h0;
         fb_src_q        <= 32'h0;
         smooth_q        <= `RST_SMOOTH;
         fb_upper_q      <= `RST_FB_UPPER;
         fb_lower_q      <= `RST_FB_LOWER;
         fb_inv_q        <= 16'h0;
         deriv_q         <= `RST_DERIV;
         kp_q            <= `RST_PROP_GAIN;
         integ_time_q    <= `RST_INTEG;
         unit_sel_q      <= `RST_UNIT_SEL;
         release_q       <= 1'b1;
      end else begin
         if (i_s_axi_awvalid && o_s_axi_awready) begin
            aw_addr_q       <= {i_s_axi_awaddr[7:2], 2'h0};
            aw_got_q        <= 1'b1;
            o_s_axi_awready <= 1'b0;
         end
         if (i_s_axi_wvalid && o_s_axi_wready) begin
            w_data_q       <= i_s_axi_wdata;
            w_strb_q       <= i_s_axi_wstrb;
            w_got_q        <= 1'b1;
            o_s_axi_wready <= 1'b0;
         end
         if (do_write) begin
            aw_got_q       <= 1'b0;
            w_got_q        <= 1'b0;
            o_s_axi_bvalid <= 1'b1;
            o_s_axi_bresp  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
            case (aw_addr_q)
               `R_UNIT_REF:   unit_ref_q <= ($signed(wr_val) < $signed(`UNIT_REF_MIN)) ?
                                            `UNIT_REF_MIN : wr_val;
               `R_SAMPLE_SEL: sample_sel_q <= wr_val[15:0];
               `R_SP_SRC:     sp_src_q <= wr_val;
               `R_RISE_TIME:  rise_q <= wr_val;
               `R_FALL_TIME:  fall_q <= wr_val;
               `R_DEV_INV:    dev_inv_q <= wr_val[15:0];
               `R_FB_SRC:     fb_src_q <= wr_val;
               `R_FB_SMOOTH:  smooth_q <= wr_val;
               `R_FB_UPPER:   fb_upper_q <= wr_val;
               `R_FB_LOWER:   fb_lower_q <= wr_val;
               `R_FB_INV:     fb_inv_q <= wr_val[15:0];
               `R_DERIV_TIME: deriv_q <= wr_val;
               `R_PROP_GAIN:  kp_q <= wr_val;
               `R_INTEG_TIME: integ_time_q <= wr_val;
               `R_UNIT_SEL:   unit_sel_q <= wr_val[15:0];
               `R_INHIBIT:    release_q <= wr_val[0];
               default: begin
               end
            endcase
         end
         if (o_s_axi_bvalid && i_s_axi_bready) begin
            o_s_axi_bvalid  <= 1'b0;
            o_s_axi_awready <= 1'b1;
            o_s_axi_wready  <= 1'b1;
         end
      end
   end

   // Register read path
   reg  [31:0] rd_val;
   reg         rd_hit;

   always @* begin
      rd_hit = 1'b1;
      case ({i_s_axi_araddr[7:2], 2'h0})
         `R_UNIT_REF:   rd_val = unit_ref_q;
         `R_SAMPLE_SEL: rd_val = {16'h0, sample_sel_q};
         `R_STATUS:     rd_val = {20'h0, o_status};
         `R_SP_SRC:     rd_val = sp_src_q;
         `R_RISE_TIME:  rd_val = rise_q;
         `R_FALL_TIME:  rd_val = fall_q;
         `R_RAMP_OUT:   rd_val = to_unit(ramp_q, abs_mode, unit_ref_q);
         `R_DEV_INV:    rd_val = {16'h0, dev_inv_q};
         `R_FB_SRC:     rd_val = fb_src_q;
         `R_FB_SMOOTH:  rd_val = smooth_q;
         `R_FB_UPPER:   rd_val = fb_upper_q;
         `R_FB_LOWER:   rd_val = fb_lower_q;
         `R_FB_INV:     rd_val = {16'h0, fb_inv_q};
         `R_FB_OUT:     rd_val = to_unit(fb_clamp_q, abs_mode, unit_ref_q);
         `R_DEV_OUT:    rd_val = to_unit(dev_q, abs_mode, unit_ref_q);
         `R_DERIV_TIME: rd_val = deriv_q;
         `R_PROP_GAIN:  rd_val = kp_q;
         `R_INTEG_TIME: rd_val = integ_time_q;
         `R_UNIT_SEL:   rd_val = {16'h0, unit_sel_q};
         `R_INHIBIT:    rd_val = {31'h0, release_q};
         `R_CTRL_OUT:   rd_val = o_speed_setpoint;
         default: begin
            rd_val = 32'h0;
            rd_hit = 1'b0;
         end
      endcase
   end

   always @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_s_axi_arready <= 1'b1;
         o_s_axi_rvalid  <= 1'b0;
         o_s_axi_rdata   <= 32'h0;
         o_s_axi_rresp   <= `RESP_OKAY;
      end else begin
         if (i_s_axi_arvalid && o_s_axi_arready) begin
            o_s_axi_arready <= 1'b0;
            o_s_axi_rvalid  <= 1'b1;
            o_s_axi_rdata   <= rd_val;
            o_s_axi_rresp   <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
         end else if (o_s_axi_rvalid && i_s_axi_rready) begin
            o_s_axi_rvalid  <= 1'b0;
            o_s_axi_arready <= 1'b1;
         end
      end
   end

endmodule

// ===== verif/pid_ctrl_sva.sv
// Port assertions for the process PID controller
`timescale 1ns/1ps
`include "free_process_pid_regs.vh"
module pid_ctrl_chk (
   // Clock and reset
   input wire        i_core_clk,
   input wire        i_arst_n,
   // Controller side
   input wire        i_enable,
   input wire [31:0] o_speed_setpoint,
   input wire [11:0] o_status,
   input wire        o_sample_tick,
   // Register bus handshakes
   input wire        i_s_axi_awvalid,
   input wire        o_s_axi_awready,
   input wire        i_s_axi_wvalid,
   input wire        o_s_axi_wready,
   input wire        o_s_axi_bvalid,
   input wire        i_s_axi_arvalid,
   input wire        o_s_axi_arready,
   input wire        o_s_axi_rvalid
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_arst_n);

   chk_tick_gap: assert property (o_sample_tick |=> !o_sample_tick [*8])
      else $error("sample ticks closer than shortest period");
   chk_out_tick: assert property ($changed(o_speed_setpoint) |-> o_sample_tick)
      else $error("output changed away from a sample tick");
   chk_out_range: assert property (o_speed_setpoint <= `OUT_MAX)
      else $error("output above its maximum");
   chk_out_max: assert property (o_sample_tick |-> o_status[`ST_OUT_MAX] == (o_speed_setpoint == `OUT_MAX))
      else $error("output-at-maximum bit disagrees with output");
   chk_limited_bit: assert property (o_status[`ST_LIMITED] |->
      (o_speed_setpoint == `OUT_MAX || o_speed_setpoint == `OUT_MIN))
      else $error("limited bit set with output inside limits");
   chk_deact_bit: assert property (!i_enable |=> o_status[`ST_DEACT])
      else $error("deactivated bit clear while switched out");
   chk_write_resp: assert property (i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready
      |-> ##2 o_s_axi_bvalid)
      else $error("write response late");
   chk_read_resp: assert property (i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid && !o_s_axi_arready)
      else $error("read answer late");
   chk_write_block: assert property (o_s_axi_bvalid |-> !o_s_axi_awready && !o_s_axi_wready)
      else $error("write accepted while response pending");
endmodule

// ===== verif/pid_src_model.sv
// Signal sources feeding the controller and consumer of its speed setpoint
`timescale 1ns/1ps
module pid_src_model (
   // Clock
   input  wire         i_clk,
   // Values chosen by the bench
   input  wire [31:0]  i_sp,
   input  wire [31:0]  i_fb,
   input  wire         i_en,
   // Towards the controller
   output wire [127:0] o_src_bus,
   output wire         o_enable,
   // Speed setpoint consumer
   input  wire         i_tick,
   input  wire [31:0]  i_spd,
   output reg  [31:0]  o_taken_q
);
   reg [31:0] noise_q = 32'h1;
   // Unused words keep moving so a wrong source pick shows
   always @(posedge i_clk) begin
      noise_q <= {noise_q[30:0], noise_q[31] ^ noise_q[21] ^ noise_q[1] ^ noise_q[0]};
      if (i_tick) begin
         o_taken_q <= i_spd;
      end
   end
   assign o_src_bus = {~noise_q, i_fb, i_sp, noise_q};
   assign o_enable  = i_en;
endmodule

// ===== verif/testbench.sv
// Self-checking bench for the process PID controller
`timescale 1ns/1ps
`include "free_process_pid_regs.vh"
module testbench;
   reg          clk, rst_n, en, awv, wv, bre, arv, rre;
   reg  [7:0]   awa, ara;
   reg  [31:0]  sp, fb, wd;
   wire         awr, wrdy, bv, arr, rv, tick, en_w;
   wire [1:0]   br, rr;
   wire [31:0]  rdat, spd, taken;
   wire [11:0]  st;
   wire [127:0] srcs;
   reg  [33:0]  q[$];
   integer      errors, n_checks, seed, i, n;

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   pid_src_model u_src (.i_clk(clk), .i_sp(sp), .i_fb(fb), .i_en(en), .o_src_bus(srcs), .o_enable(en_w),
      .i_tick(tick), .i_spd(spd), .o_taken_q(taken));
   free_process_pid_controller #(.BASE_CYCLES(16)) DUT (.i_core_clk(clk), .i_arst_n(rst_n),
      .i_src_bus(srcs), .i_enable(en_w), .o_speed_setpoint(spd), .o_status(st), .o_sample_tick(tick),
      .i_s_axi_awvalid(awv), .o_s_axi_awready(awr), .i_s_axi_awaddr(awa), .i_s_axi_wvalid(wv),
      .o_s_axi_wready(wrdy), .i_s_axi_wdata(wd), .i_s_axi_wstrb(4'hf), .o_s_axi_bvalid(bv),
      .i_s_axi_bready(bre), .o_s_axi_bresp(br), .i_s_axi_arvalid(arv), .o_s_axi_arready(arr),
      .i_s_axi_araddr(ara), .o_s_axi_rvalid(rv), .i_s_axi_rready(rre), .o_s_axi_rdata(rdat),
      .o_s_axi_rresp(rr));

   task report_and_stop;
      begin
         $display("checks=%0d errors=%0d", n_checks, errors);
         if (errors == 0 && n_checks > 0) begin
            $display("STATUS OK");
         end else begin
            $display("STATUS NOT OK");
         end
         $finish;
      end
   endtask
   task chk(input [33:0] g, input [33:0] e);
      begin
         n_checks = n_checks + 1;
         if (g !== e) begin
            errors = errors + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
         end
      end
   endtask
   // Answers are taken off the queue as they appear
   always @(posedge clk) begin
      if (rv && rre) chk({rr, rdat}, q.pop_front());
      if (bv && bre) chk({br, 32'h0}, q.pop_front());
   end
   task wr(input [7:0] a, input [31:0] d, input [1:0] r = 2'h0);
      begin
         q.push_back({r, 32'h0});
         @(posedge clk);
         awv <= 1'b1;
         wv  <= 1'b1;
         awa <= a;
         wd  <= d;
         bre <= 1'b1;
         do begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wrdy) wv <= 1'b0;
         end while (!bv);
         bre <= 1'b0;
      end
   endtask
   task rd(input [7:0] a, input [31:0] d, input [1:0] r = 2'h0);
      begin
         q.push_back({r, d});
         @(posedge clk);
         arv <= 1'b1;
         ara <= a;
         rre <= 1'b1;
         do begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
         end while (!rv);
         rre <= 1'b0;
      end
   endtask
   task ticks(input integer k);
      integer j;
      begin
         for (j = 0; j < k; j = j + 1) begin
            // Skip a pulse launched at the calling edge
            @(posedge clk);
            @(posedge clk);
            while (!tick) @(posedge clk);
         end
      end
   endtask
   task run_case(input [31:0] s, f, dinv, finv, kp, edev, efb, eout, input [3:0] ehi);
      begin
         wr(`R_DEV_INV, dinv);
         wr(`R_FB_INV, finv);
         wr(`R_PROP_GAIN, kp);
         sp <= s;
         fb <= f;
         ticks(2);
         rd(`R_DEV_OUT, edev);
         rd(`R_FB_OUT, efb);
         rd(`R_CTRL_OUT, eout);
         chk({2'h0, taken}, {2'h0, eout});
         chk({30'h0, st[11:8]}, {30'h0, ehi});
         $display("case sp=%h fb=%h done", s, f);
      end
   endtask

   initial begin
      #(8 * 20000);
      errors = errors + 1;
      report_and_stop;
   end
   initial begin
      errors = 0;
      n_checks = 0;
      seed = 16;
      {rst_n, en, awv, wv, bre, arv, rre} = 7'h0;
      {sp, fb, wd, awa, ara} = 112'h0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      rd(`R_UNIT_REF, `RST_UNIT_REF);
      rd(`R_SAMPLE_SEL, {16'h0, `RST_SAMPLE_SEL});
      rd(`R_STATUS, 32'h1);
      rd(`R_RISE_TIME, `RST_RAMP_TIME);
      rd(`R_FALL_TIME, `RST_RAMP_TIME);
      rd(`R_FB_SMOOTH, `RST_SMOOTH);
      rd(`R_FB_UPPER, `RST_FB_UPPER);
      rd(`R_FB_LOWER, `RST_FB_LOWER);
      rd(`R_FB_INV, 32'h0);
      rd(`R_DERIV_TIME, `RST_DERIV);
      rd(`R_PROP_GAIN, `RST_PROP_GAIN);
      rd(`R_INTEG_TIME, `RST_INTEG);
      rd(8'h60, 32'h0, `RESP_SLVERR);
      wr(`R_STATUS, 32'h5, `RESP_SLVERR);
      wr(8'h7c, 32'h5, `RESP_SLVERR);
      $display("register test done");
      wr(`R_SP_SRC, 32'h1);
      wr(`R_FB_SRC, 32'h2);
      wr(`R_RISE_TIME, 32'h0);
      wr(`R_FALL_TIME, 32'h0);
      wr(`R_INTEG_TIME, 32'h0);
      wr(`R_DEV_INV, 32'h0);
      en <= 1'b1;
      for (i = 1; i <= 4; i = i + 1) begin
         wr(`R_SAMPLE_SEL, i);
         ticks(1);
         n = 0;
         do begin
            @(posedge clk);
            n = n + 1;
         end while (!tick);
         chk(n, 32'd16 << (i - 1));
      end
      wr(`R_SAMPLE_SEL, 32'h0);
      n = 0;
      repeat (300) begin
         @(posedge clk);
         if (tick) n = n + 1;
      end
      chk(n, 0);
      chk(st[0], 1);
      wr(`R_SAMPLE_SEL, 32'h1);
      ticks(1);
      chk(st[0], 0);
      $display("sampling test done");
      for (i = 0; i < 3; i = i + 1) begin
         sp <= $random(seed) & 32'h0000_ffff;
         fb <= 32'h0;
         ticks(2);
         rd(`R_DEV_OUT, sp);
         chk(taken, sp);
      end
      run_case(32'h8000, 32'h4000, 0, 0, 32'h10000, 32'h4000, 32'h4000, 32'h4000, 4'h0);
      run_case(32'h8000, 32'h4000, 1, 0, 32'h10000, 32'hffffc000, 32'h4000, 32'h0, 4'h4);
      run_case(32'h8000, 32'h18000, 0, 0, 32'h10000, 32'hffff8000, 32'h10000, 32'h0, 4'h6);
      run_case(32'h8000, 32'h4000, 0, 1, 32'h10000, 32'hc000, 32'hffffc000, 32'hc000, 4'h0);
      run_case(32'h8000, 32'hfffe8000, 0, 0, 32'h10000, 32'h18000, 32'hffff0000, 32'h10000, 4'h9);
      run_case(32'h8000, 32'h4000, 0, 0, 32'h0, 32'h4000, 32'h4000, 32'h0, 4'h4);
      run_case(32'h8000, 32'h4000, 0, 0, 32'h20000, 32'h4000, 32'h4000, 32'h8000, 4'h0);
      sp <= 32'h4000;
      ticks(1);
      wr(`R_PROP_GAIN, 32'h10000);
      wr(`R_INTEG_TIME, 32'h80);
      sp <= 32'h8000;
      ticks(1);
      rd(`R_CTRL_OUT, 32'h8000);
      wr(`R_INTEG_TIME, 32'h0);
      fb <= 32'h2000;
      ticks(2);
      rd(`R_CTRL_OUT, 32'ha000);
      $display("integral test done");
      wr(`R_RISE_TIME, 32'h400);
      wr(`R_FALL_TIME, 32'h200);
      sp <= 32'hc000;
      ticks(1);
      rd(`R_RAMP_OUT, 32'ha000);
      ticks(1);
      rd(`R_RAMP_OUT, 32'hc000);
      sp <= 32'h0;
      ticks(1);
      rd(`R_RAMP_OUT, 32'h8000);
      $display("ramp test done");
      wr(`R_RISE_TIME, 32'h0);
      wr(`R_FALL_TIME, 32'h0);
      sp <= 32'h4000;
      wr(`R_UNIT_REF, 32'h1);
      rd(`R_UNIT_REF, `UNIT_REF_MIN);
      wr(`R_UNIT_REF, 32'h20000);
      wr(`R_UNIT_SEL, 32'h2);
      ticks(2);
      rd(`R_RAMP_OUT, 32'h8000);
      en <= 1'b0;
      ticks(2);
      chk(taken, 0);
      chk(st[0], 1);
      $display("unit and switch-out test done");
      report_and_stop;
   end
endmodule

bind free_process_pid_controller pid_ctrl_chk u_chk (.i_core_clk, .i_arst_n, .i_enable, .o_speed_setpoint,
   .o_status, .o_sample_tick, .i_s_axi_awvalid, .o_s_axi_awready, .i_s_axi_wvalid, .o_s_axi_wready,
   .o_s_axi_bvalid, .i_s_axi_arvalid, .o_s_axi_arready, .o_s_axi_rvalid);
